// *** verilog/wfd_map.vh ***
// Register indexes, field positions, reset values and frame constants of the
// wake frame detector. Included by the detector top and shared with the bench.
`ifndef WFD_MAP_VH
`define WFD_MAP_VH

// Register indexes; the APB byte address is four times the index.
`define WFD_IDX_BASIC_CTRL 10'h000
`define WFD_IDX_CONFIG 10'h134
`define WFD_IDX_STATUS 10'h135
`define WFD_IDX_IRQ_MASK 10'h136
`define WFD_IDX_ADDR_LO 10'h137
`define WFD_IDX_ADDR_HI 10'h138
`define WFD_IDX_PASS_LO 10'h139
`define WFD_IDX_PASS_HI 10'h13a
`define WFD_IDX_PAT_BASE 10'h140
`define WFD_IDX_PAT_LAST 10'h14f

// Field positions.
`define WFD_BASIC_ISOLATE 10
`define WFD_CFG_MAGIC_EN 0
`define WFD_CFG_PAT_EN 1
`define WFD_CFG_BCAST_EN 2
`define WFD_CFG_UCAST_EN 3
`define WFD_CFG_SECURE_EN 4
`define WFD_CFG_GPIO_EN 5
`define WFD_STS_MAGIC 0
`define WFD_STS_PATTERN 1
`define WFD_STS_CRC_BAD 2

// Reset values.
`define WFD_BASIC_RST 16'h0000
`define WFD_CONFIG_RST 6'h00
`define WFD_MASK_RST 3'h0

// Frame constants.
`define WFD_SYNC_LEN 3'h6
`define WFD_ADDR_LAST 3'h5
`define WFD_REPS_LAST 4'hf
`define WFD_PAT_BYTES 7'h40
`define WFD_MIN_FRAME 7'h12
`define WFD_CNT_MAX 7'h7f
`define WFD_CRC_INIT 32'hffffffff
`define WFD_CRC_POLY 32'hedb88320
`define WFD_CRC_RESIDUE 32'hdebb20e3

`endif

// *** verilog/wfd_crc32.v ***
// Byte-wide Ethernet CRC-32 accumulator, least significant bit first.
// Assumes the caller clears it between frames and feeds every frame byte.
`timescale 1ns/1ps
`default_nettype none
`include "wfd_map.vh"

module wfd_crc32 (
  input wire clk,
  input wire rst,
  input wire clear,
  input wire enable,
  input wire [7:0] dataIn,
  output wire [31:0] crc
);

  reg [31:0] crc_r;
  reg [31:0] crc_nxt;
  integer i;

  always @* begin
    crc_nxt = crc_r;
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_nxt[0] ^ dataIn[i]) begin
        crc_nxt = (crc_nxt >> 1) ^ `WFD_CRC_POLY;
      end else begin
        crc_nxt = crc_nxt >> 1;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_r <= `WFD_CRC_INIT;
    end else if (clear) begin
      crc_r <= `WFD_CRC_INIT;
    end else if (enable) begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;

endmodule // wfd_crc32
`default_nettype wire

// *** verilog/wfd_top.v ***
// Wake frame detector: scans received frames for a magic sequence or a
// stored pattern and raises a wake request, an interrupt and a GPIO level.
// Assumes a byte stream on clk from the receive path, framed by frameDv,
// with preamble and start delimiter already stripped, and an APB master.
`timescale 1ns/1ps
`default_nettype none
`include "wfd_map.vh"

// Notes on behaviour
// R1: Magic frames recognised at 1000, 100 and 10 Mb/s alike.
// R2: A valid magic frame raises the wake-up interrupt.
// R3: A bad frame check sequence suppresses the wake-up interrupt; the code still raises irq for it via status bit 2 when mask bit 2 is set.
// R4: With security on, the password must follow the sixteen addresses at once.
// R5: One 64-byte software pattern wakes just like a magic frame.
// R6: Broadcast and unicast waking are enabled separately.
// R7: In magic mode every frame addressed to this node is searched.
// R8: The magic sequence opens with six bytes of all ones.
// R9: Then the station address follows sixteen times with no gaps.
// R10: The magic sequence may start at any byte position.
// R11: A GPIO output can signal a received wake frame.
// R12: The sender places the magic sequence on byte boundaries.
// R13: Only well formed frames with own or broadcast destination are candidates.
// R14: While the port isolate bit is set no wake interrupt is raised.
// R15: A qualifying wake frame brings the device out of low power.
// R16: Configuration and status live at indexes 0x0134 and 0x0135.
// R17: A breaking byte restarts the sync search without losing an overlapping start.
module wfd_top (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire frameDv,
  input wire byteValid,
  input wire [7:0] byteData,
  output wire irq,
  output wire wakeReq,
  output wire wakeGpio,
  output wire macPortIsolate
);

  localparam [1:0] ST_SYNC = 2'd0;
  localparam [1:0] ST_ADDR = 2'd1;
  localparam [1:0] ST_PASS = 2'd2;
  localparam [1:0] ST_DONE = 2'd3;

  // Register file.
  reg [15:0] basicCtrl_r;
  reg [5:0] config_r;
  reg [2:0] status_r;
  reg [2:0] irqMask_r;
  reg [47:0] stationAddr_r;
  reg [47:0] password_r;
  reg [31:0] patMem [0:15];
  reg [31:0] prdata_r;
  reg pslverr_r;

  // Frame scanning state.
  reg inFrame_r;
  reg [6:0] byteCnt_r;
  reg destOwn_r;
  reg destBcast_r;
  reg patOk_r;
  reg [1:0] state_r;
  reg [2:0] ffCnt_r;
  reg [2:0] pos_r;
  reg [3:0] rep_r;
  reg magicHit_r;
  reg irq_r;
  reg wakeReq_r;
  reg wakeGpio_r;

  wire [9:0] wordIdx;
  wire setupPhase;
  wire writeTaken;
  wire patSel;
  wire [3:0] patWord;
  wire take;
  wire isFf;
  wire [7:0] addrByte;
  wire [7:0] passByte;
  wire [7:0] destByte;
  wire [7:0] patByte;
  wire [31:0] crcValue;
  wire frameEnd;
  wire wellFormed;
  wire destOk;
  wire magicCand;
  wire patCand;
  wire crcOk;
  wire evMagic;
  wire evPattern;
  wire evCrcBad;
  wire [2:0] events;
  wire [2:0] w1c;
  wire isolate;

  reg [31:0] rdMux;
  reg rdErr;

  function [7:0] pickByte;
    input [47:0] v;
    input [2:0] i;
    begin
      case (i)
        3'd0: pickByte = v[7:0];
        3'd1: pickByte = v[15:8];
        3'd2: pickByte = v[23:16];
        3'd3: pickByte = v[31:24];
        3'd4: pickByte = v[39:32];
        default: pickByte = v[47:40];
      endcase
    end
  endfunction

  // APB slave: answers with no wait state; read data is caught in setup.
  assign wordIdx = paddr[11:2];
  assign setupPhase = psel & ~penable;
  assign writeTaken = psel & penable & pwrite;
  assign patSel = (wordIdx >= `WFD_IDX_PAT_BASE) && (wordIdx <= `WFD_IDX_PAT_LAST);
  assign patWord = wordIdx[3:0];
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  always @* begin
    rdMux = 32'h00000000;
    rdErr = 1'b0;
    if (wordIdx == `WFD_IDX_BASIC_CTRL) begin
      rdMux = {16'h0000, basicCtrl_r};
    end else if (wordIdx == `WFD_IDX_CONFIG) begin
      rdMux = {26'h0000000, config_r}; // R16
    end else if (wordIdx == `WFD_IDX_STATUS) begin
      rdMux = {29'h00000000, status_r}; // R16
    end else if (wordIdx == `WFD_IDX_IRQ_MASK) begin
      rdMux = {29'h00000000, irqMask_r};
    end else if (wordIdx == `WFD_IDX_ADDR_LO) begin
      rdMux = stationAddr_r[31:0];
    end else if (wordIdx == `WFD_IDX_ADDR_HI) begin
      rdMux = {16'h0000, stationAddr_r[47:32]};
    end else if (wordIdx == `WFD_IDX_PASS_LO) begin
      rdMux = password_r[31:0];
    end else if (wordIdx == `WFD_IDX_PASS_HI) begin
      rdMux = {16'h0000, password_r[47:32]};
    end else if (patSel) begin
      rdMux = patMem[patWord];
    end else begin
      rdErr = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setupPhase) begin
      prdata_r <= pwrite ? 32'h00000000 : rdMux;
      pslverr_r <= rdErr;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      basicCtrl_r <= `WFD_BASIC_RST;
      config_r <= `WFD_CONFIG_RST;
      irqMask_r <= `WFD_MASK_RST;
      stationAddr_r <= 48'h000000000000;
      password_r <= 48'h000000000000;
    end else if (writeTaken) begin
      if (wordIdx == `WFD_IDX_BASIC_CTRL) begin
        basicCtrl_r <= pwdata[15:0];
      end else if (wordIdx == `WFD_IDX_CONFIG) begin
        config_r <= pwdata[5:0]; // R16
      end else if (wordIdx == `WFD_IDX_IRQ_MASK) begin
        irqMask_r <= pwdata[2:0];
      end else if (wordIdx == `WFD_IDX_ADDR_LO) begin
        stationAddr_r[31:0] <= pwdata;
      end else if (wordIdx == `WFD_IDX_ADDR_HI) begin
        stationAddr_r[47:32] <= pwdata[15:0];
      end else if (wordIdx == `WFD_IDX_PASS_LO) begin
        password_r[31:0] <= pwdata;
      end else if (wordIdx == `WFD_IDX_PASS_HI) begin
        password_r[47:32] <= pwdata[15:0];
      end
    end
  end

  // Pattern memory has no reset; software loads it before enabling it.
  always @(posedge clk) begin
    if (writeTaken && patSel) begin
      patMem[patWord] <= pwdata; // R5
    end
  end

  // Byte stream. It is byte wide at every line speed, so one path serves all.
  assign take = frameDv & byteValid; // R1 R12
  assign isFf = (byteData == 8'hff);
  assign addrByte = pickByte(stationAddr_r, pos_r);
  assign passByte = pickByte(password_r, pos_r);
  assign destByte = pickByte(stationAddr_r, byteCnt_r[2:0]);
  assign patByte = patMem[byteCnt_r[5:2]][{byteCnt_r[1:0], 3'b000} +: 8];
  assign frameEnd = inFrame_r & ~frameDv;

  wfd_crc32 crcUnit (
    .clk(clk),
    .rst(rst),
    .clear(~frameDv),
    .enable(take),
    .dataIn(byteData),
    .crc(crcValue)
  );

  // Per-frame bookkeeping: length, destination and stored pattern.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      inFrame_r <= 1'b0;
      byteCnt_r <= 7'h00;
      destOwn_r <= 1'b1;
      destBcast_r <= 1'b1;
      patOk_r <= 1'b1;
    end else begin
      inFrame_r <= frameDv;
      if (!frameDv) begin
        byteCnt_r <= 7'h00;
        destOwn_r <= 1'b1;
        destBcast_r <= 1'b1;
        patOk_r <= 1'b1;
      end else if (byteValid) begin
        if (byteCnt_r != `WFD_CNT_MAX) begin
          byteCnt_r <= byteCnt_r + 7'h01;
        end
        if (byteCnt_r < 7'h06) begin
          destOwn_r <= destOwn_r & (byteData == destByte); // R13
          destBcast_r <= destBcast_r & isFf; // R13
        end
        if (byteCnt_r < `WFD_PAT_BYTES && byteData != patByte) begin
          patOk_r <= 1'b0; // R5
        end
      end
    end
  end

  // Magic sequence search. The search runs over the whole frame, so the
  // sequence may sit anywhere; a breaking byte that is itself all ones
  // already counts as the first byte of a new sync run.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_SYNC;
      ffCnt_r <= 3'h0;
      pos_r <= 3'h0;
      rep_r <= 4'h0;
      magicHit_r <= 1'b0;
    end else if (!frameDv) begin
      state_r <= ST_SYNC;
      ffCnt_r <= 3'h0;
      pos_r <= 3'h0;
      rep_r <= 4'h0;
      magicHit_r <= 1'b0;
    end else if (byteValid) begin
      case (state_r) // R7 R10
        ST_SYNC: begin
          if (isFf) begin
            if (ffCnt_r != `WFD_SYNC_LEN) begin
              ffCnt_r <= ffCnt_r + 3'h1; // R8
            end
          end else if (ffCnt_r == `WFD_SYNC_LEN && byteData == addrByte) begin
            state_r <= ST_ADDR; // R8
            pos_r <= 3'h1;
            rep_r <= 4'h0;
            ffCnt_r <= 3'h0;
          end else begin
            ffCnt_r <= 3'h0; // R17
          end
        end
        ST_ADDR: begin
          if (byteData == addrByte) begin
            if (pos_r == `WFD_ADDR_LAST) begin
              pos_r <= 3'h0;
              if (rep_r == `WFD_REPS_LAST) begin // R9
                if (config_r[`WFD_CFG_SECURE_EN]) begin
                  state_r <= ST_PASS; // R4
                end else begin
                  state_r <= ST_DONE;
                  magicHit_r <= 1'b1;
                end
              end else begin
                rep_r <= rep_r + 4'h1; // R9
              end
            end else begin
              pos_r <= pos_r + 3'h1;
            end
          end else begin
            state_r <= ST_SYNC; // R17
            pos_r <= 3'h0;
            rep_r <= 4'h0;
            ffCnt_r <= isFf ? 3'h1 : 3'h0; // R17
          end
        end
        ST_PASS: begin
          if (byteData == passByte) begin
            if (pos_r == `WFD_ADDR_LAST) begin
              state_r <= ST_DONE; // R4
              magicHit_r <= 1'b1;
              pos_r <= 3'h0;
            end else begin
              pos_r <= pos_r + 3'h1;
            end
          end else begin
            state_r <= ST_SYNC; // R4 R17
            pos_r <= 3'h0;
            rep_r <= 4'h0;
            ffCnt_r <= isFf ? 3'h1 : 3'h0;
          end
        end
        default: begin
          state_r <= ST_DONE;
        end
      endcase
    end
  end

  // Frame verdict, taken in the cycle after frameDv falls.
  assign wellFormed = (byteCnt_r >= `WFD_MIN_FRAME); // R13
  assign destOk = (destOwn_r & config_r[`WFD_CFG_UCAST_EN]) |
                  (destBcast_r & config_r[`WFD_CFG_BCAST_EN]); // R6
  assign magicCand = config_r[`WFD_CFG_MAGIC_EN] & magicHit_r; // R7
  assign patCand = config_r[`WFD_CFG_PAT_EN] & patOk_r &
                   (byteCnt_r >= `WFD_PAT_BYTES); // R5
  assign crcOk = (crcValue == `WFD_CRC_RESIDUE); // R3
  assign evMagic = frameEnd & wellFormed & destOk & magicCand & crcOk; // R2 R3
  assign evPattern = frameEnd & wellFormed & destOk & patCand & crcOk; // R5 R3
  assign evCrcBad = frameEnd & wellFormed & destOk & (magicCand | patCand) & ~crcOk;
  assign events = {evCrcBad, evPattern, evMagic};

  // Status bits are sticky and cleared by writing ones; a new event wins.
  assign w1c = (writeTaken && wordIdx == `WFD_IDX_STATUS) ? pwdata[2:0] : 3'h0;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= 3'h0;
    end else begin
      status_r <= (status_r & ~w1c) | events;
    end
  end

  // Outputs. The interrupt is held off while the MAC port is isolated.
  assign isolate = basicCtrl_r[`WFD_BASIC_ISOLATE];

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
      wakeReq_r <= 1'b0;
      wakeGpio_r <= 1'b0;
    end else begin
      irq_r <= (|(status_r & irqMask_r)) & ~isolate; // R2 R14
      wakeReq_r <= status_r[`WFD_STS_MAGIC] | status_r[`WFD_STS_PATTERN]; // R15
      wakeGpio_r <= config_r[`WFD_CFG_GPIO_EN] &
                    (status_r[`WFD_STS_MAGIC] | status_r[`WFD_STS_PATTERN]); // R11
    end
  end

  assign irq = irq_r;
  assign wakeReq = wakeReq_r;
  assign wakeGpio = wakeGpio_r;
  assign macPortIsolate = isolate; // R14

endmodule // wfd_top
`default_nettype wire

// *** bench/wfd_top_asserts.sv ***
// Port checker for the wake frame detector.
// Assumes it is bound to wfd_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module wfd_top_asserts (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire frameDv,
  input wire irq,
  input wire wakeReq,
  input wire wakeGpio,
  input wire macPortIsolate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire clrW = acc && pwrite && paddr[11:2] == 10'h135;
  sequence sMid;
    frameDv [*3];
  endsequence
  sequence sIsoWr;
    acc && pwrite && paddr[11:2] == 10'h000;
  endsequence
  AST_WAKE_END: assert property ($rose(wakeReq) |-> $past(frameDv, 3) && !$past(frameDv, 2))
    else $error("wake rose away from a frame end");
  AST_NO_WAKE_MID: assert property (sMid |-> !$rose(wakeReq))
    else $error("wake rose inside a frame");
  AST_STICKY: assert property ($fell(wakeReq) |-> $past(clrW, 2))
    else $error("wake fell without a status clear");
  AST_GPIO: assert property (wakeGpio |-> wakeReq)
    else $error("gpio high without wake");
  AST_ISO_IRQ: assert property (macPortIsolate |=> !irq)
    else $error("irq high while isolated");
  AST_ISO_WR: assert property (sIsoWr |=> macPortIsolate == $past(pwdata[10]))
    else $error("isolate bit not written");
  AST_UNMAP: assert property (acc && paddr[11:2] == 10'h100 |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (acc && paddr[11:2] == 10'h134 |-> !pslverr)
    else $error("config access refused");
  AST_READY: assert property (psel |-> pready)
    else $error("pready low");
endmodule // wfd_top_asserts

bind wfd_top wfd_top_asserts chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .frameDv(frameDv), .irq(irq), .wakeReq(wakeReq), .wakeGpio(wakeGpio),
  .macPortIsolate(macPortIsolate));
`default_nettype wire

// *** bench/wfd_station.sv ***
// Remote station model: sends the frame held in q, with its FCS appended.
// Assumes the caller fills q with whole bytes and waits for send to return.
`timescale 1ns/1ps
`default_nettype none
module wfd_station (
  input wire clk,
  output logic frameDv,
  output logic byteValid,
  output logic [7:0] byteData
);
  logic [7:0] q[$];
  initial begin
    frameDv = 1'b0;
    byteValid = 1'b0;
    byteData = 8'h00;
  end
  task automatic send(input logic bad, input int gap);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < q.size(); i++) begin
      c = c ^ {24'h000000, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    c = ~c ^ {31'h0, bad};
    for (int k = 0; k < 4; k++) q.push_back(c[8*k +: 8]);
    @(posedge clk);
    frameDv <= 1'b1;
    // Whole bytes only, so the sequence stays byte aligned.
    foreach (q[i]) begin
      byteValid <= 1'b1;
      byteData <= q[i];
      @(posedge clk);
      repeat (gap) begin
        byteValid <= 1'b0;
        byteData <= ~q[i];
        @(posedge clk);
      end
    end
    frameDv <= 1'b0;
    byteValid <= 1'b0;
    byteData <= ~byteData;
    q.delete();
  endtask
endmodule // wfd_station
`default_nettype wire

// *** bench/test_wfd_top.sv ***
// Testbench of the wake frame detector.
// Assumes the station model drives frames and APB is driven here.
`timescale 1ns/1ps
`default_nettype none
`include "wfd_map.vh"
module test_wfd_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire [7:0] byteData;
  wire pready, pslverr, frameDv, byteValid, irq, wakeReq, wakeGpio, macPortIsolate;
  logic [31:0] rd;
  logic er;
  int fail_count = 0;
  int comparisons = 0;
  localparam logic [47:0] MAC = 48'h665544332211;
  localparam logic [47:0] PW = 48'h2f2e2d2c2b2a;
  always #2.5 clk = ~clk;
  wfd_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frameDv(frameDv), .byteValid(byteValid), .byteData(byteData), .irq(irq),
    .wakeReq(wakeReq), .wakeGpio(wakeGpio), .macPortIsolate(macPortIsolate));
  wfd_station st (.clk(clk), .frameDv(frameDv), .byteValid(byteValid), .byteData(byteData));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task mk(input logic [47:0] dst, input int reps, input logic pw);
    for (int k = 0; k < 6; k++) st.q.push_back(dst[8*k +: 8]);
    for (int k = 0; k < 6; k++) st.q.push_back(8'h02 + 8'(k));
    // A broken run first, so the search has to restart.
    st.q = {st.q, 8'hff, 8'hff, 8'hff, 8'h11};
    for (int k = 0; k < 6; k++) st.q.push_back(8'hff);
    for (int r = 0; r < reps; r++)
      for (int k = 0; k < 6; k++) st.q.push_back(MAC[8*k +: 8]);
    if (pw) for (int k = 0; k < 6; k++) st.q.push_back(PW[8*k +: 8]);
    st.q = {st.q, 8'h00, 8'h5a};
  endtask
  task run(input logic bad, input int gap, input logic [2:0] sts, input logic [2:0] outs);
    st.send(bad, gap);
    repeat (3) @(posedge clk);
    chk("gpio irq wake", {29'h0, wakeGpio, irq, wakeReq}, {29'h0, outs});
    apb(1'b0, `WFD_IDX_STATUS, 32'h0);
    chk("status", rd, {29'h0, sts});
    apb(1'b1, `WFD_IDX_STATUS, 32'h7);
    repeat (2) @(posedge clk);
    chk("cleared", {30'h0, irq, wakeReq}, 32'h0);
  endtask
  task t_regs;
    apb(1'b0, `WFD_IDX_CONFIG, 32'h0);
    chk("config reset", rd, 32'h0);
    apb(1'b0, `WFD_IDX_IRQ_MASK, 32'h0);
    chk("mask reset", rd, 32'h0);
    apb(1'b0, 10'h100, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    apb(1'b1, 10'h100, 32'hffffffff);
    chk("unmapped write", {31'h0, er}, 32'h1);
    apb(1'b1, `WFD_IDX_CONFIG, 32'h3f);
    apb(1'b0, `WFD_IDX_CONFIG, 32'h0);
    chk("config", rd, 32'h3f);
    $display("test regs done");
  endtask
  task t_magic;
    apb(1'b1, `WFD_IDX_CONFIG, 32'h29);
    mk(MAC, 15, 1'b0);
    run(1'b0, 0, 3'h0, 3'b000);
    mk(MAC, 16, 1'b0);
    run(1'b0, 0, 3'h1, 3'b111);
    mk(MAC, 16, 1'b0);
    run(1'b0, 9, 3'h1, 3'b111);
    mk(MAC, 16, 1'b0);
    run(1'b1, 0, 3'h4, 3'b010);
    mk(48'h0a0b0c0d0e0f, 16, 1'b0);
    run(1'b0, 0, 3'h0, 3'b000);
    $display("test magic done");
  endtask
  task t_bcast;
    mk(48'hffffffffffff, 16, 1'b0);
    run(1'b0, 0, 3'h0, 3'b000);
    apb(1'b1, `WFD_IDX_CONFIG, 32'h25);
    mk(48'hffffffffffff, 16, 1'b0);
    run(1'b0, 0, 3'h1, 3'b111);
    mk(MAC, 16, 1'b0);
    run(1'b0, 0, 3'h0, 3'b000);
    $display("test broadcast done");
  endtask
  task t_secure;
    apb(1'b1, `WFD_IDX_CONFIG, 32'h39);
    mk(MAC, 16, 1'b0);
    run(1'b0, 0, 3'h0, 3'b000);
    mk(MAC, 16, 1'b1);
    run(1'b0, 0, 3'h1, 3'b111);
    $display("test password done");
  endtask
  task t_pattern;
    apb(1'b1, `WFD_IDX_CONFIG, 32'h2a);
    mk(MAC, 2, 1'b0);
    repeat (32) st.q.push_back(8'h3c);
    for (int i = 0; i < 16; i++)
      apb(1'b1, `WFD_IDX_PAT_BASE + 10'(i),
        {st.q[4*i+3], st.q[4*i+2], st.q[4*i+1], st.q[4*i]});
    run(1'b0, 0, 3'h2, 3'b111);
    $display("test pattern done");
  endtask
  task t_iso;
    // Gpio is left off here, so its enable is seen working both ways.
    apb(1'b1, `WFD_IDX_CONFIG, 32'h09);
    apb(1'b1, `WFD_IDX_BASIC_CTRL, 32'h400);
    @(posedge clk);
    chk("isolate", {31'h0, macPortIsolate}, 32'h1);
    mk(MAC, 16, 1'b0);
    run(1'b0, 0, 3'h1, 3'b001);
    apb(1'b1, `WFD_IDX_BASIC_CTRL, 32'h0);
    $display("test isolate done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    apb(1'b1, `WFD_IDX_ADDR_LO, MAC[31:0]);
    apb(1'b1, `WFD_IDX_ADDR_HI, {16'h0, MAC[47:32]});
    apb(1'b1, `WFD_IDX_PASS_LO, PW[31:0]);
    apb(1'b1, `WFD_IDX_PASS_HI, {16'h0, PW[47:32]});
    apb(1'b1, `WFD_IDX_IRQ_MASK, 32'h7);
    t_magic;
    t_bcast;
    t_secure;
    t_pattern;
    t_iso;
    test_done;
  end
endmodule // test_wfd_top
`default_nettype wire
